// file: ddrcd_decoder.sv
`timescale 1ns/100ps
`default_nettype none
`include "ddrcd_map.svh"
module ddrcd_decoder #(
  parameter int XP_CYCLES = `DDRCD_XP_CYCLES,
  parameter int BURST_RISES = `DDRCD_BURST_RISES,
  parameter int BANK_COUNT = `DDRCD_BANK_COUNT
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic sys_enable,
  input wire logic mem_clk,
  input wire logic chip_select_n,
  input wire logic mem_clk_enable,
  input wire logic [`DDRCD_CA_WIDTH-1:0] cmd_addr_bus,
  output logic cmd_valid,
  output ddrcd_pkg::ddrcd_cmd_type cmd_code,
  output logic [7:0] mode_reg_index,
  output logic [7:0] mode_reg_value,
  output logic [14:0] row_addr,
  output logic [11:0] col_addr,
  output logic [2:0] slice_select,
  output logic auto_close_flag,
  output logic all_bank_flag,
  output logic illegal_cmd,
  output logic burst_busy,
  output logic auto_precharge_strobe,
  output ddrcd_pkg::ddrcd_pwr_type power_state,
  output logic cmd_ready,
  output logic reinit_needed
);
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  localparam int SW = `DDRCD_CA_WIDTH + 3;
  logic [SW-1:0] pin_meta;
  logic [SW-1:0] pin_sync;
  logic ck_d;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_meta <= '0;
      pin_sync <= '0;
      ck_d <= 1'b0;
    end else if (sys_enable) begin
      pin_meta <= {mem_clk, chip_select_n, mem_clk_enable, cmd_addr_bus};
      pin_sync <= pin_meta;
      ck_d <= pin_sync[SW-1];
    end
  end
  logic s_ck, s_cs_n, s_cke, rise, fall;
  logic [`DDRCD_CA_WIDTH-1:0] s_ca;
  assign s_ck = pin_sync[SW-1];
  assign s_cs_n = pin_sync[SW-2];
  assign s_cke = pin_sync[SW-3];
  assign s_ca = pin_sync[`DDRCD_CA_WIDTH-1:0];
  assign rise = s_ck & ~ck_d;
  assign fall = ~s_ck & ck_d;

  // ---------------------------------------------------------------
  // edge capture and word joining
  // ---------------------------------------------------------------
  logic cke_prev, cke_cur, cs_cur, half_ok, word_ready;
  logic [`DDRCD_CA_WIDTH-1:0] ca_r, ca_f;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cke_prev <= 1'b0;
      cke_cur <= 1'b0;
      cs_cur <= 1'b1;
      ca_r <= '0;
      ca_f <= '0;
      half_ok <= 1'b0;
      word_ready <= 1'b0;
    end else if (sys_enable) begin
      word_ready <= 1'b0;
      if (rise) begin
        cke_prev <= cke_cur;
        cke_cur <= s_cke;
        cs_cur <= s_cs_n;
        ca_r <= s_ca;
        half_ok <= 1'b1;
      end else if (fall && half_ok) begin
        ca_f <= s_ca;
        half_ok <= 1'b0;
        word_ready <= 1'b1;
      end
    end
  end

  function automatic ddrcd_pkg::ddrcd_cmd_type decode_cmd(
    input logic cs_n, input logic [3:0] ca);
    ddrcd_pkg::ddrcd_cmd_type c;
    c = ddrcd_pkg::CMD_NOP;
    if (!cs_n) begin
      casez (ca)
        4'b0000: c = ddrcd_pkg::CMD_MRW;
        4'b1000: c = ddrcd_pkg::CMD_MRR;
        4'b0100: c = ddrcd_pkg::CMD_REF_ONE;
        4'b1100: c = ddrcd_pkg::CMD_REF_ALL;
        4'b??10: c = ddrcd_pkg::CMD_ACT;
        4'b?001: c = ddrcd_pkg::CMD_WRITE;
        4'b?101: c = ddrcd_pkg::CMD_READ;
        4'b1011: c = ddrcd_pkg::CMD_PRE;
        4'b0011: c = ddrcd_pkg::CMD_BST;
        default: c = ddrcd_pkg::CMD_NOP;
      endcase
    end
    return c;
  endfunction : decode_cmd

  // ---------------------------------------------------------------
  // command decode and field extraction
  // ---------------------------------------------------------------
  ddrcd_pkg::ddrcd_cmd_type next_cmd;
  logic accept;
  assign next_cmd = decode_cmd(cs_cur, ca_r[3:0]);
  assign accept = word_ready && cke_prev && cke_cur && cmd_ready;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cmd_valid <= 1'b0;
      cmd_code <= ddrcd_pkg::CMD_NOP;
      mode_reg_index <= 8'h00;
      mode_reg_value <= 8'h00;
      row_addr <= 15'h0000;
      col_addr <= 12'h000;
      slice_select <= 3'h0;
      auto_close_flag <= 1'b0;
      all_bank_flag <= 1'b0;
      illegal_cmd <= 1'b0;
    end else if (sys_enable) begin
      cmd_valid <= accept;
      illegal_cmd <= accept && next_cmd == ddrcd_pkg::CMD_REF_ONE &&
                     BANK_COUNT != 8;
      if (accept) begin
        cmd_code <= next_cmd;
        mode_reg_index <= {ca_f[1:0], ca_r[9:`DDRCD_IDX_LO_POS]};
        mode_reg_value <= ca_f[9:2];
        row_addr <= {ca_f[9:8], ca_r[6:2], ca_f[7:0]};
        col_addr <= {ca_f[9:1], ca_r[6:5], 1'b0};
        slice_select <= ca_r[9:`DDRCD_SLICE_POS];
        auto_close_flag <= ca_f[`DDRCD_AUTO_CLOSE_POS];
        all_bank_flag <= ca_r[`DDRCD_ALL_BANK_POS];
      end
    end
  end

  // ---------------------------------------------------------------
  // burst tracking and auto precharge
  // ---------------------------------------------------------------
  // burst length is counted in memory clock rises; data path is elsewhere
  logic [7:0] burst_left;
  logic ac_pending;
  logic is_rw;
  assign is_rw = cmd_valid && (cmd_code == ddrcd_pkg::CMD_READ ||
                               cmd_code == ddrcd_pkg::CMD_WRITE);
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      burst_left <= 8'h00;
      burst_busy <= 1'b0;
      ac_pending <= 1'b0;
      auto_precharge_strobe <= 1'b0;
    end else if (sys_enable) begin
      auto_precharge_strobe <= 1'b0;
      if (is_rw) begin
        burst_left <= 8'(BURST_RISES);
        burst_busy <= 1'b1;
        ac_pending <= auto_close_flag;
      end else if (cmd_valid && cmd_code == ddrcd_pkg::CMD_BST) begin
        burst_left <= 8'h00;
        burst_busy <= 1'b0;
        auto_precharge_strobe <= ac_pending;
        ac_pending <= 1'b0;
      end else if (rise && burst_busy) begin
        // a no-op leaves the count running
        burst_left <= burst_left - 8'h01;
        if (burst_left == 8'h01) begin
          burst_busy <= 1'b0;
          auto_precharge_strobe <= ac_pending;
          ac_pending <= 1'b0;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // power states and exit timing
  // ---------------------------------------------------------------
  logic [15:0] xp_left;
  logic [1:0] rises_seen;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      power_state <= ddrcd_pkg::PWR_ACTIVE;
      reinit_needed <= 1'b0;
      xp_left <= 16'h0000;
      rises_seen <= 2'h2;
      cmd_ready <= 1'b1;
    end else if (sys_enable) begin
      cmd_ready <= power_state == ddrcd_pkg::PWR_ACTIVE &&
                   xp_left == 16'h0000 &&
                   rises_seen >= 2'(`DDRCD_STABLE_RISES);
      if (xp_left != 16'h0000) begin
        xp_left <= xp_left - 16'h0001;
      end
      if (rise && rises_seen != 2'h2) begin
        rises_seen <= rises_seen + 2'h1;
      end
      case (power_state)
        ddrcd_pkg::PWR_ACTIVE: begin
          if (rise && cke_cur && !s_cke) begin
            if (s_cs_n) begin
              power_state <= ddrcd_pkg::PWR_LOW_POWER;
            end else if (s_ca[2:0] == 3'h4) begin
              power_state <= ddrcd_pkg::PWR_SELF_REFRESH;
            end else if (s_ca[2:0] == 3'h3) begin
              power_state <= ddrcd_pkg::PWR_DEEP_SLEEP;
            end
          end
        end
        ddrcd_pkg::PWR_LOW_POWER: begin
          // stays put while enable is low, whatever else shows
          if (rise && s_cke) begin
            power_state <= ddrcd_pkg::PWR_ACTIVE;
            xp_left <= 16'(XP_CYCLES);
            rises_seen <= 2'h0;
          end
        end
        ddrcd_pkg::PWR_SELF_REFRESH, ddrcd_pkg::PWR_DEEP_SLEEP: begin
          // clock may be stopped here, so no edge is awaited
          if (s_cke) begin
            // sticky: only a full reset clears the need to reinitialise
            if (power_state == ddrcd_pkg::PWR_DEEP_SLEEP) begin
              reinit_needed <= 1'b1;
            end
            power_state <= ddrcd_pkg::PWR_ACTIVE;
            xp_left <= 16'(XP_CYCLES);
            rises_seen <= 2'h0;
          end
        end
        default: power_state <= ddrcd_pkg::PWR_ACTIVE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst || !sys_enable);

  sequence s_close_access;
    is_rw && auto_close_flag;
  endsequence
  sequence s_precharge_seen;
    ##[1:400] auto_precharge_strobe;
  endsequence

  a_decode_joined: assert property (accept |=> cmd_valid &&
    cmd_code == decode_cmd(cs_cur, ca_r[3:0]))
    else $error("command not decoded after both halves");
  a_mrw_fields: assert property (cmd_valid &&
    cmd_code == ddrcd_pkg::CMD_MRW |-> mode_reg_value == ca_f[9:2] &&
    mode_reg_index == {ca_f[1:0], ca_r[9:4]})
    else $error("mode register write fields wrong");
  a_col_zero_lsb: assert property (is_rw |-> col_addr[0] == 1'b0 &&
    col_addr[11:3] == ca_f[9:1] && auto_close_flag == ca_f[0])
    else $error("column field wrong");
  a_act_row_map: assert property (cmd_valid &&
    cmd_code == ddrcd_pkg::CMD_ACT |-> row_addr[12:8] == ca_r[6:2] &&
    row_addr[14:13] == ca_f[9:8] && slice_select == ca_r[9:7])
    else $error("activate row field wrong");
  a_nop_keeps_burst: assert property (burst_busy &&
    burst_left > 8'h01 && cmd_valid && cmd_code == ddrcd_pkg::CMD_NOP
    |=> burst_busy)
    else $error("no-op ended a burst");
  a_auto_close_pre: assert property (s_close_access |->
    s_precharge_seen)
    else $error("auto precharge missing");
  a_pd_entry_hold: assert property (power_state ==
    ddrcd_pkg::PWR_ACTIVE && rise && cke_cur && !s_cke && s_cs_n
    |=> power_state == ddrcd_pkg::PWR_LOW_POWER)
    else $error("power-down not entered");
  a_lp_maintain: assert property (power_state !=
    ddrcd_pkg::PWR_ACTIVE && !s_cke |=> power_state == $past(power_state))
    else $error("low-power state left with enable low");
  a_sr_async_exit: assert property (power_state ==
    ddrcd_pkg::PWR_SELF_REFRESH && s_cke && !rise
    |=> power_state == ddrcd_pkg::PWR_ACTIVE)
    else $error("self refresh exit waited for clock");
  a_ready_gate: assert property (cmd_valid |-> $past(cmd_ready))
    else $error("command accepted before exit delay");
endmodule : ddrcd_decoder
`default_nettype wire

// file: ddrcd_map.svh
// Summary of operation
// - commands decode only from chip select, cmd_addr_bus 0-3 and clock enable.
// - select and clock enable taken on rising edges; address on both edges.
// - no_op_cmd is select high, or select low with bits 0-2 high.
// - no_op_cmd never cuts short a running read or write burst.
// - mode_reg_write_cmd: bits 0-3 low; index rise and fall, value on fall.
// - mode_reg_read_cmd: bits 0-2 low, bit 3 high; index split over edges.
// - bits 0,1 low, bit 2 high: refresh one bank or all banks.
// - auto_close_flag high precharges the bank after the access.
// - lowest column bit is never sent and always taken as zero.
// - clock enable low on two edges keeps the current low-power state.
// - leaving self refresh and deep sleep is caught without clock edges.
// - commands resume only once two clock rises and power_down_exit_delay have both passed.
// - enable low with select high at a rising edge enters power-down.
// - enable low, select low, bits 0,1 high, bit 2 low: deep sleep.
`ifndef DDRCD_MAP_SVH
`define DDRCD_MAP_SVH
`define DDRCD_CLK_MHZ 100
`define DDRCD_XP_NS 15
`define DDRCD_XP_CYCLES ((`DDRCD_XP_NS * `DDRCD_CLK_MHZ + 999) / 1000)
`define DDRCD_STABLE_RISES 2
`define DDRCD_BURST_RISES 4
`define DDRCD_BANK_COUNT 8
`define DDRCD_CA_WIDTH 10
`define DDRCD_IDX_LO_POS 4
`define DDRCD_SLICE_POS 7
`define DDRCD_ALL_BANK_POS 4
`define DDRCD_AUTO_CLOSE_POS 0
`endif

// file: ddrcd_pkg.sv
`default_nettype none
package ddrcd_pkg;
  typedef enum logic [3:0] {
    CMD_NOP, CMD_MRW, CMD_MRR, CMD_REF_ONE, CMD_REF_ALL, CMD_ACT,
    CMD_WRITE, CMD_READ, CMD_PRE, CMD_BST
  } ddrcd_cmd_type;
  typedef enum logic [1:0] {
    PWR_ACTIVE, PWR_LOW_POWER, PWR_SELF_REFRESH, PWR_DEEP_SLEEP
  } ddrcd_pwr_type;
endpackage : ddrcd_pkg
`default_nettype wire

// file: ddrcd_ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// controller side: one clock frame per request
// ----------------------------------------
module ddrcd_ctrl_model (
  input wire logic clk_sys,
  input wire logic req,
  input wire logic slow,
  input wire logic req_cke,
  input wire logic req_cs_n,
  input wire logic [9:0] req_rise,
  input wire logic [9:0] req_fall,
  output logic ack,
  output logic mem_clk,
  output logic chip_select_n,
  output logic mem_clk_enable,
  output logic [9:0] cmd_addr_bus
);
  realtime q;
  // enable is a plain level; the bench clocks three low frames before raising it
  assign mem_clk_enable = req_cke;
  initial begin
    ack = 1'b0;
    mem_clk = 1'b0;
    chip_select_n = 1'b1;
    cmd_addr_bus = 10'h000;
    forever begin
      @(posedge clk_sys);
      if (req === 1'b1) begin
        // slow frames stretch the period; quarters keep each cycle whole
        q = slow ? 62.5 : 31.25;
        #1;
        chip_select_n = req_cs_n;
        cmd_addr_bus = req_rise;
        #(q);
        mem_clk = 1'b1;
        #(q);
        cmd_addr_bus = req_fall;
        #(q);
        mem_clk = 1'b0;
        #(q);
        // bus released: inverse of last value, clock parked low
        cmd_addr_bus = ~req_fall;
        chip_select_n = 1'b1;
        @(posedge clk_sys);
        #1 ack = 1'b1;
        @(posedge clk_sys);
        #1 ack = 1'b0;
      end
    end
  end
endmodule : ddrcd_ctrl_model
`default_nettype wire

// file: ddr_command_decode_clocking_tb.sv
`timescale 1ns/100ps
`default_nettype none
module ddr_command_decode_clocking_tb;
  logic clk_sys = 1'b0, rst = 1'b1, req = 1'b0, slow = 1'b0, ack;
  logic req_cke = 1'b1, req_cs_n = 1'b1;
  logic [9:0] req_rise = 10'h000, req_fall = 10'h000, cmd_addr_bus;
  logic mem_clk, chip_select_n, mem_clk_enable, cmd_valid, illegal_cmd;
  logic auto_close_flag, all_bank_flag, burst_busy, auto_precharge_strobe;
  logic cmd_ready, reinit_needed;
  logic [7:0] mode_reg_index, mode_reg_value;
  logic [14:0] row_addr;
  logic [11:0] col_addr;
  logic [2:0] slice_select;
  ddrcd_pkg::ddrcd_cmd_type cmd_code;
  ddrcd_pkg::ddrcd_pwr_type power_state;
  int error_cnt = 0, checked = 0, vcnt = 0, scnt = 0, icnt = 0, v0, s0;
  localparam logic [15:0] pwr_lp = 16'(ddrcd_pkg::PWR_LOW_POWER);
  localparam logic [15:0] pwr_sr = 16'(ddrcd_pkg::PWR_SELF_REFRESH);
  localparam logic [15:0] pwr_ds = 16'(ddrcd_pkg::PWR_DEEP_SLEEP);
  always #5 clk_sys = ~clk_sys;
  ddrcd_ctrl_model ctrl_u (.clk_sys(clk_sys), .req(req), .slow(slow),
    .req_cke(req_cke), .req_cs_n(req_cs_n), .req_rise(req_rise),
    .req_fall(req_fall), .ack(ack), .mem_clk(mem_clk),
    .chip_select_n(chip_select_n), .mem_clk_enable(mem_clk_enable),
    .cmd_addr_bus(cmd_addr_bus));
  ddrcd_decoder dut_u (.clk_sys(clk_sys), .rst(rst), .sys_enable(1'b1),
    .mem_clk(mem_clk), .chip_select_n(chip_select_n),
    .mem_clk_enable(mem_clk_enable), .cmd_addr_bus(cmd_addr_bus),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .mode_reg_index(mode_reg_index), .mode_reg_value(mode_reg_value),
    .row_addr(row_addr), .col_addr(col_addr), .slice_select(slice_select),
    .auto_close_flag(auto_close_flag), .all_bank_flag(all_bank_flag),
    .illegal_cmd(illegal_cmd), .burst_busy(burst_busy),
    .auto_precharge_strobe(auto_precharge_strobe),
    .power_state(power_state), .cmd_ready(cmd_ready),
    .reinit_needed(reinit_needed));
  // ----------------------------------------
  // pulse monitor: one-cycle outputs are counted where they stand
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (cmd_valid === 1'b1) vcnt++;
    if (auto_precharge_strobe === 1'b1) scnt++;
    if (illegal_cmd === 1'b1) icnt++;
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic wrap_up;
    if (error_cnt == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input string name, input logic [15:0] exp,
                     input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic send(input logic cke, input logic csn,
                      input logic [9:0] r, input logic [9:0] f);
    int n;
    n = 0;
    req_cke = cke;
    req_cs_n = csn;
    req_rise = r;
    req_fall = f;
    req = 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (ack !== 1'b1 && n < 200);
    // taken at the edge that saw ack, before the model drops it
    chk("ack", 16'h0001, {15'h0000, ack});
    #1 req = 1'b0;
    // decode lands four edges after the falling half
    repeat (6) @(posedge clk_sys);
    #1;
  endtask : send
  task automatic cmd(input logic csn, input logic [9:0] r,
                     input logic [9:0] f, input logic [3:0] code);
    v0 = vcnt;
    send(1'b1, csn, r, f);
    chk("cmd_valid count", 16'(v0 + 1), 16'(vcnt));
    chk("cmd_code", {12'h000, code}, {12'h000, cmd_code});
  endtask : cmd
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    wrap_up;
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    #1 rst = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    send(1'b1, 1'b1, 10'h000, 10'h000);
    send(1'b1, 1'b1, 10'h000, 10'h000);
    cmd(1'b1, 10'h000, 10'h000, ddrcd_pkg::CMD_NOP);
    cmd(1'b0, 10'h3f7, 10'h000, ddrcd_pkg::CMD_NOP);
    cmd(1'b0, 10'h250, 10'h0f2, ddrcd_pkg::CMD_MRW);
    chk("mode_reg_index", 16'h00a5, 16'(mode_reg_index));
    chk("mode_reg_value", 16'h003c, 16'(mode_reg_value));
    slow = 1'b1;
    cmd(1'b0, 10'h1a8, 10'h3fd, ddrcd_pkg::CMD_MRR);
    slow = 1'b0;
    chk("mode_reg_index", 16'h005a, 16'(mode_reg_index));
    cmd(1'b0, 10'h2a4, 10'h155, ddrcd_pkg::CMD_REF_ONE);
    cmd(1'b0, 10'h00c, 10'h000, ddrcd_pkg::CMD_REF_ALL);
    chk("illegal_cmd count", 16'h0000, 16'(icnt));
    cmd(1'b0, 10'h36e, 10'h23c, ddrcd_pkg::CMD_ACT);
    chk("row_addr", 16'h5b3c, 16'(row_addr));
    chk("slice_select", 16'h0006, 16'(slice_select));
    s0 = scnt;
    cmd(1'b0, 10'h1e1, 10'h2ad, ddrcd_pkg::CMD_WRITE);
    chk("col_addr", 16'h0ab6, 16'(col_addr));
    chk("slice_select", 16'h0003, 16'(slice_select));
    chk("auto_close_flag", 16'h0001, 16'(auto_close_flag));
    repeat (3) cmd(1'b1, 10'h000, 10'h000, ddrcd_pkg::CMD_NOP);
    chk("burst_busy", 16'h0001, 16'(burst_busy));
    chk("strobe count", 16'(s0), 16'(scnt));
    cmd(1'b1, 10'h000, 10'h000, ddrcd_pkg::CMD_NOP);
    chk("burst_busy", 16'h0000, 16'(burst_busy));
    chk("strobe count", 16'(s0 + 1), 16'(scnt));
    cmd(1'b0, 10'h005, 10'h000, ddrcd_pkg::CMD_READ);
    chk("burst_busy", 16'h0001, 16'(burst_busy));
    cmd(1'b0, 10'h003, 10'h000, ddrcd_pkg::CMD_BST);
    chk("burst_busy", 16'h0000, 16'(burst_busy));
    chk("strobe count", 16'(s0 + 1), 16'(scnt));
    cmd(1'b0, 10'h29b, 10'h000, ddrcd_pkg::CMD_PRE);
    chk("all_bank_flag", 16'h0001, 16'(all_bank_flag));
    chk("slice_select", 16'h0005, 16'(slice_select));
    send(1'b0, 1'b1, 10'h000, 10'h000);
    chk("power_state", pwr_lp, 16'(power_state));
    v0 = vcnt;
    send(1'b0, 1'b0, 10'h000, 10'h000);
    chk("power_state", pwr_lp, 16'(power_state));
    chk("cmd_valid count", 16'(v0), 16'(vcnt));
    send(1'b0, 1'b1, 10'h000, 10'h000);
    chk("power_state", pwr_lp, 16'(power_state));
    send(1'b1, 1'b1, 10'h000, 10'h000);
    chk("power_state", 16'(ddrcd_pkg::PWR_ACTIVE), 16'(power_state));
    repeat (2) send(1'b1, 1'b1, 10'h000, 10'h000);
    chk("cmd_ready", 16'h0001, 16'(cmd_ready));
    send(1'b0, 1'b0, 10'h004, 10'h000);
    chk("power_state", pwr_sr, 16'(power_state));
    repeat (2) send(1'b0, 1'b1, 10'h000, 10'h000);
    chk("power_state", pwr_sr, 16'(power_state));
    req_cke = 1'b1;
    repeat (8) @(posedge clk_sys);
    chk("power_state", 16'(ddrcd_pkg::PWR_ACTIVE), 16'(power_state));
    repeat (2) send(1'b1, 1'b1, 10'h000, 10'h000);
    chk("cmd_ready", 16'h0001, 16'(cmd_ready));
    chk("reinit_needed", 16'h0000, 16'(reinit_needed));
    send(1'b0, 1'b0, 10'h003, 10'h000);
    chk("power_state", pwr_ds, 16'(power_state));
    repeat (2) send(1'b0, 1'b1, 10'h000, 10'h000);
    chk("power_state", pwr_ds, 16'(power_state));
    req_cke = 1'b1;
    repeat (8) @(posedge clk_sys);
    chk("power_state", 16'(ddrcd_pkg::PWR_ACTIVE), 16'(power_state));
    chk("reinit_needed", 16'h0001, 16'(reinit_needed));
    wrap_up;
  end
endmodule : ddr_command_decode_clocking_tb
`default_nettype wire
